// [common/audio_watch_if.sv]
// Audio stream descriptors watched for changes, and the change flags
interface audio_watch_if;
	logic [3:0] audio_type;
	logic [7:0] aif_checksum;
	logic [7:0] avi_checksum;
	logic [39:0] acr_fields;
	logic [3:0] changed;
	modport detector
	(
		input audio_type,
		input aif_checksum,
		input avi_checksum,
		input acr_fields,
		output changed
	);
	modport owner
	(
		output audio_type,
		output aif_checksum,
		output avi_checksum,
		output acr_fields,
		input changed
	);
endinterface : audio_watch_if

// [common/bridge_audio_link_map.svh]
// Register offsets, field positions, masks and reset values of the bridge control registers
`ifndef BRIDGE_AUDIO_LINK_MAP_SVH
`define BRIDGE_AUDIO_LINK_MAP_SVH

// Register offsets
`define BRIDGE_STATUS_OFS 8'h50
`define BRIDGE_CONTROL_OFS 8'h54
`define AUDIO_ROUTING_CONFIG_OFS 8'h55
`define LINK_STATUS_OFS 8'h5A
`define LOW_FREQ_THRESHOLD_OFS 8'h5D

// Bridge control fields
`define EXTERNAL_CONTROL_BIT 7
`define RX_IRQ_ENABLE_BIT 6
`define REMOTE_EDID_LOAD_DISABLE_BIT 5
`define AUTO_INITIALIZATION_DISABLE_BIT 4
`define TDM_AUDIO_ENABLE_BIT 2
`define AUDIO_SOURCE_LOCAL_BIT 1
`define AUX_AUDIO_ENABLE_BIT 0
`define BRIDGE_CONTROL_MASK 8'hF7
`define BRIDGE_CONTROL_RESET 8'h00

// Audio routing fields
`define TDM_TO_PARALLEL_BIT 7
`define RX_I2S_OUT_ENABLE_BIT 6
`define FIFO_RESET_POLICY_MSB 3
`define FIFO_RESET_ON_AUDIO_INFOFRAME_BIT 2
`define FIFO_RESET_ON_VIDEO_INFOFRAME_BIT 1
`define FIFO_RESET_ON_CLOCK_REGEN_BIT 0
`define AUDIO_ROUTING_MASK 8'hCF
`define AUDIO_ROUTING_RESET 8'h0C

// Link status fields
`define DOWNSTREAM_LINK_READY_BIT 7
`define SERIAL_TRANSMIT_ACTIVE_BIT 6
`define SERIAL_PORT_MODE_MSB 5
`define SERIAL_PORT_MODE_LSB 4
`define TMDS_DATA_GOOD_BIT 3
`define RX_PLL_LOCK_BIT 2
`define NO_TMDS_CLOCK_BIT 1
`define INPUT_FREQUENCY_SETTLED_BIT 0
`define LINK_STATUS_RESET 8'h00

// Bridge status field
`define RX_IRQ_PENDING_BIT 6
`define BRIDGE_STATUS_RESET 8'h00

// Low frequency threshold, in MHz
`define LOW_FREQ_THRESHOLD_MASK 8'h3F
`define LOW_FREQ_THRESHOLD_RESET 8'h06

`endif

// [common/bridge_audio_link_pkg.sv]
// Types shared by the bridge control register block
package bridge_audio_link_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [39:0] watch_lane_t;
	typedef enum logic [1:0]
	{
		PORT_MODE_NONE = 2'h0,
		PORT_MODE_SINGLE_PORT0 = 2'h1
	} port_mode_t;
endpackage : bridge_audio_link_pkg

// [hw/audio_change_detect.sv]
// Per-descriptor change detector feeding the audio FIFO reset policy
module audio_change_detect
	import bridge_audio_link_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	audio_watch_if.detector watch
);
	watch_lane_t lane [4];
	logic armed_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// Widen each descriptor to a common lane so one loop serves all four
	assign lane[0] = {36'h0, watch.audio_type};
	assign lane[1] = {32'h0, watch.aif_checksum};
	assign lane[2] = {32'h0, watch.avi_checksum};
	assign lane[3] = watch.acr_fields;

	// First sample only primes history, so reset release is not a change
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			armed_q <= 1'b0;
		else
			armed_q <= 1'b1;
	end

	for (genvar i = 0; i < 4; i++)
	begin : g_lane
		watch_lane_t prev_q;
		logic hit_q;

		// History and one-cycle change pulse for this descriptor
		always_ff @(posedge sys_clk or negedge resetn)
		begin
			if (!resetn)
			begin
				prev_q <= 40'h0;
				hit_q <= 1'b0;
			end
			else
			begin
				prev_q <= lane[i];
				hit_q <= armed_q && (lane[i] != prev_q);
			end
		end
		assign watch.changed[i] = hit_q;

		// Judged from the descriptor's own history, not from prev_q
		lane_change_a: assert property (armed_q && $changed(lane[i])
			|=> watch.changed[i])
			else $error("descriptor change not flagged");
		lane_still_a: assert property ($stable(lane[i]) |=> !watch.changed[i])
			else $error("change flagged without a change");
	end
endmodule : audio_change_detect

// [hw/bridge_audio_link_ctrl_regs.sv]
// Bridge control, audio routing and link status registers with their control outputs
`include "bridge_audio_link_map.svh"

module bridge_audio_link_ctrl_regs
	import bridge_audio_link_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic config_strap_pin_a,
	input wire logic config_strap_pin_b,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_read,
	input wire logic rx_irq,
	input wire logic downstream_detect,
	input wire logic downstream_caps_done,
	input wire logic serial_tx_running,
	input wire logic far_rx_locked,
	input wire logic input_valid,
	input wire logic [1:0] serial_port_mode,
	input wire logic tmds_good,
	input wire logic rx_pll_locked,
	input wire logic [7:0] tmds_freq_mhz,
	input wire logic freq_settled,
	input wire logic [3:0] audio_type,
	input wire logic [7:0] aif_checksum,
	input wire logic [7:0] avi_checksum,
	input wire logic [19:0] acr_n,
	input wire logic [19:0] acr_cts,
	output logic [7:0] reg_rdata,
	output logic interrupt_out_n,
	output logic sequencer_enable,
	output logic rx_auto_init,
	output logic remote_edid_load,
	output logic tdm_audio_enable,
	output logic audio_source_local,
	output logic aux_audio_enable,
	output logic tdm_to_parallel_enable,
	output logic i2s_out_enable,
	output logic audio_fifo_reset
);
	reg_byte_t bridge_control_q;
	reg_byte_t audio_routing_q;
	reg_byte_t threshold_q;
	reg_byte_t link_status_q;
	reg_byte_t bridge_status_q;
	reg_byte_t rdata_q;
	reg_byte_t read_mux;
	logic strap_done_q;
	logic irq_n_q;
	logic seq_en_q;
	logic auto_init_q;
	logic edid_load_q;
	logic tdm_q;
	logic local_q;
	logic aux_q;
	logic t2p_q;
	logic i2s_q;
	logic fifo_reset_q;
	logic tx_ok;
	logic fifo_cause;
	logic [3:0] policy;

	audio_watch_if watch ();

	// Descriptors handed to the change detector
	assign watch.audio_type = audio_type;
	assign watch.aif_checksum = aif_checksum;
	assign watch.avi_checksum = avi_checksum;
	assign watch.acr_fields = {acr_n, acr_cts};

	audio_change_detect u_detect
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.watch(watch)
	);

	// Strap capture happens once, on the first edge after reset release
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			strap_done_q <= 1'b0;
		else
			strap_done_q <= 1'b1;
	end

	// Bridge control; strap load takes priority over a same-cycle write
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			bridge_control_q <= `BRIDGE_CONTROL_RESET;
		else if (!strap_done_q)
		begin
			bridge_control_q[`EXTERNAL_CONTROL_BIT] <= config_strap_pin_b;
			bridge_control_q[`REMOTE_EDID_LOAD_DISABLE_BIT] <= config_strap_pin_b;
			bridge_control_q[`AUX_AUDIO_ENABLE_BIT] <= config_strap_pin_a;
		end
		else if (reg_write && reg_addr == `BRIDGE_CONTROL_OFS)
			bridge_control_q <= reg_wdata & `BRIDGE_CONTROL_MASK;
	end

	// Audio routing and FIFO reset policy
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			audio_routing_q <= `AUDIO_ROUTING_RESET;
		else if (reg_write && reg_addr == `AUDIO_ROUTING_CONFIG_OFS)
			audio_routing_q <= reg_wdata & `AUDIO_ROUTING_MASK;
	end

	// Six-bit low frequency threshold in MHz
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			threshold_q <= `LOW_FREQ_THRESHOLD_RESET;
		else if (reg_write && reg_addr == `LOW_FREQ_THRESHOLD_OFS)
			threshold_q <= reg_wdata & `LOW_FREQ_THRESHOLD_MASK;
	end

	// Transmit status needs every precondition and the single-port mode
	assign tx_ok = serial_tx_running && far_rx_locked && input_valid
		&& serial_port_mode == PORT_MODE_SINGLE_PORT0;

	// Status snapshot; writes never reach it
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			link_status_q <= `LINK_STATUS_RESET;
			bridge_status_q <= `BRIDGE_STATUS_RESET;
		end
		else
		begin
			link_status_q[`DOWNSTREAM_LINK_READY_BIT] <= downstream_detect
				&& downstream_caps_done;
			link_status_q[`SERIAL_TRANSMIT_ACTIVE_BIT] <= tx_ok;
			link_status_q[`SERIAL_PORT_MODE_MSB:`SERIAL_PORT_MODE_LSB] <= tx_ok ?
				serial_port_mode : PORT_MODE_NONE;
			link_status_q[`TMDS_DATA_GOOD_BIT] <= tmds_good;
			link_status_q[`RX_PLL_LOCK_BIT] <= rx_pll_locked;
			link_status_q[`NO_TMDS_CLOCK_BIT] <= tmds_freq_mhz <= threshold_q;
			link_status_q[`INPUT_FREQUENCY_SETTLED_BIT] <= freq_settled;
			bridge_status_q[`RX_IRQ_PENDING_BIT] <= rx_irq;
		end
	end

	// Read mux; unmapped addresses and reserved bits read zero
	always_comb
	begin
		read_mux = 8'h00;
		unique case (reg_addr)
			`BRIDGE_STATUS_OFS: read_mux = bridge_status_q;
			`BRIDGE_CONTROL_OFS: read_mux = bridge_control_q;
			`AUDIO_ROUTING_CONFIG_OFS: read_mux = audio_routing_q;
			`LINK_STATUS_OFS: read_mux = link_status_q;
			`LOW_FREQ_THRESHOLD_OFS: read_mux = threshold_q;
			default: read_mux = 8'h00;
		endcase
	end

	// Read data held until the next read
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			rdata_q <= 8'h00;
		else if (reg_read)
			rdata_q <= read_mux;
	end

	// Interrupt pin is a masked copy of the receive controller's request
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			irq_n_q <= 1'b1;
		else
			irq_n_q <= !(bridge_control_q[`RX_IRQ_ENABLE_BIT] && rx_irq);
	end

	// Sequencer controls; external control shuts out the internal sequencer
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			seq_en_q <= 1'b0;
			auto_init_q <= 1'b0;
			edid_load_q <= 1'b0;
		end
		else
		begin
			seq_en_q <= strap_done_q && !bridge_control_q[`EXTERNAL_CONTROL_BIT];
			auto_init_q <= strap_done_q && !bridge_control_q[`EXTERNAL_CONTROL_BIT]
				&& !bridge_control_q[`AUTO_INITIALIZATION_DISABLE_BIT];
			edid_load_q <= strap_done_q
				&& !bridge_control_q[`REMOTE_EDID_LOAD_DISABLE_BIT];
		end
	end

	// Audio path steering
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tdm_q <= 1'b0;
			local_q <= 1'b0;
			aux_q <= 1'b0;
			t2p_q <= 1'b0;
			i2s_q <= 1'b0;
		end
		else
		begin
			tdm_q <= bridge_control_q[`TDM_AUDIO_ENABLE_BIT];
			local_q <= bridge_control_q[`AUDIO_SOURCE_LOCAL_BIT];
			aux_q <= bridge_control_q[`AUX_AUDIO_ENABLE_BIT];
			t2p_q <= audio_routing_q[`TDM_TO_PARALLEL_BIT];
			// Local audio owns the I2S pins as inputs, so the output is blocked
			i2s_q <= audio_routing_q[`RX_I2S_OUT_ENABLE_BIT]
				&& !bridge_control_q[`AUDIO_SOURCE_LOCAL_BIT];
		end
	end

	// Policy bits, detector order: type, audio infoframe, video infoframe, clock regen
	assign policy = {audio_routing_q[`FIFO_RESET_ON_CLOCK_REGEN_BIT],
		audio_routing_q[`FIFO_RESET_ON_VIDEO_INFOFRAME_BIT],
		audio_routing_q[`FIFO_RESET_ON_AUDIO_INFOFRAME_BIT],
		audio_routing_q[`FIFO_RESET_POLICY_MSB]};
	assign fifo_cause = |(watch.changed & policy);

	// One-cycle FIFO reset; only the internal sequencer issues it
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			fifo_reset_q <= 1'b0;
		else
			fifo_reset_q <= fifo_cause && seq_en_q;
	end

	assign reg_rdata = rdata_q;
	assign interrupt_out_n = irq_n_q;
	assign sequencer_enable = seq_en_q;
	assign rx_auto_init = auto_init_q;
	assign remote_edid_load = edid_load_q;
	assign tdm_audio_enable = tdm_q;
	assign audio_source_local = local_q;
	assign aux_audio_enable = aux_q;
	assign tdm_to_parallel_enable = t2p_q;
	assign i2s_out_enable = i2s_q;
	assign audio_fifo_reset = fifo_reset_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence fifo_event_s;
		fifo_cause && seq_en_q;
	endsequence
	sequence fifo_pulse_s;
		fifo_reset_q ##1 (!fifo_reset_q || $past(fifo_cause && seq_en_q));
	endsequence

	ext_blocks_seq_a: assert property (bridge_control_q[`EXTERNAL_CONTROL_BIT]
		|=> !seq_en_q && !auto_init_q)
		else $error("sequencer active under external control");
	strap_load_a: assert property ($rose(strap_done_q) |->
		bridge_control_q[`EXTERNAL_CONTROL_BIT] == $past(config_strap_pin_b)
		&& bridge_control_q[`REMOTE_EDID_LOAD_DISABLE_BIT] == $past(config_strap_pin_b)
		&& bridge_control_q[`AUX_AUDIO_ENABLE_BIT] == $past(config_strap_pin_a))
		else $error("strap value not loaded");
	irq_pin_a: assert property (bridge_control_q[`RX_IRQ_ENABLE_BIT] && rx_irq
		|=> !irq_n_q)
		else $error("enabled interrupt not on pin");
	irq_masked_a: assert property (!(bridge_control_q[`RX_IRQ_ENABLE_BIT] && rx_irq)
		|=> irq_n_q)
		else $error("masked interrupt reached pin");
	edid_bypass_a: assert property (bridge_control_q[`REMOTE_EDID_LOAD_DISABLE_BIT]
		|=> !edid_load_q)
		else $error("remote EDID load not bypassed");
	edid_load_a: assert property (strap_done_q
		&& !bridge_control_q[`REMOTE_EDID_LOAD_DISABLE_BIT] |=> edid_load_q)
		else $error("remote EDID load not started");
	auto_init_a: assert property (strap_done_q
		&& !bridge_control_q[`EXTERNAL_CONTROL_BIT]
		&& !bridge_control_q[`AUTO_INITIALIZATION_DISABLE_BIT] |=> auto_init_q)
		else $error("auto initialization not started");
	i2s_ignore_a: assert property (bridge_control_q[`AUDIO_SOURCE_LOCAL_BIT]
		|=> !i2s_q)
		else $error("I2S output driven with local audio");
	fifo_reset_a: assert property (fifo_event_s |=> fifo_pulse_s)
		else $error("audio FIFO reset missing");
	fifo_quiet_a: assert property (!fifo_cause |=> !fifo_reset_q)
		else $error("audio FIFO reset without cause");
	link_ready_a: assert property (link_status_q[`DOWNSTREAM_LINK_READY_BIT] |->
		$past(downstream_detect) && $past(downstream_caps_done))
		else $error("link ready without connection");
	tx_status_a: assert property (link_status_q[`SERIAL_TRANSMIT_ACTIVE_BIT] |->
		$past(serial_tx_running) && $past(far_rx_locked) && $past(input_valid))
		else $error("transmit status without its preconditions");
	port_field_a: assert property (!link_status_q[`SERIAL_TRANSMIT_ACTIVE_BIT] |->
		link_status_q[`SERIAL_PORT_MODE_MSB:`SERIAL_PORT_MODE_LSB] == PORT_MODE_NONE)
		else $error("port mode shown without transmit");
	rx_status_a: assert property (strap_done_q |->
		link_status_q[`TMDS_DATA_GOOD_BIT] == $past(tmds_good)
		&& link_status_q[`RX_PLL_LOCK_BIT] == $past(rx_pll_locked)
		&& link_status_q[`INPUT_FREQUENCY_SETTLED_BIT] == $past(freq_settled))
		else $error("receive status bits not following their sources");
	no_clock_a: assert property (strap_done_q |=> link_status_q[`NO_TMDS_CLOCK_BIT]
		== ($past(tmds_freq_mhz) <= $past(threshold_q)))
		else $error("no-clock flag wrong");
	irq_pending_a: assert property (strap_done_q |->
		bridge_status_q[`RX_IRQ_PENDING_BIT] == $past(rx_irq))
		else $error("interrupt pending bit not following request");
	steer_follow_a: assert property (strap_done_q |->
		tdm_q == $past(bridge_control_q[`TDM_AUDIO_ENABLE_BIT])
		&& local_q == $past(bridge_control_q[`AUDIO_SOURCE_LOCAL_BIT])
		&& aux_q == $past(bridge_control_q[`AUX_AUDIO_ENABLE_BIT])
		&& t2p_q == $past(audio_routing_q[`TDM_TO_PARALLEL_BIT]))
		else $error("audio steering output not following its bit");
	status_ro_a: assert property (reg_write && reg_addr == `LINK_STATUS_OFS |=>
		link_status_q[`SERIAL_TRANSMIT_ACTIVE_BIT] == $past(tx_ok))
		else $error("status changed by write");
endmodule : bridge_audio_link_ctrl_regs

// [tb/reg_host_model.sv]
// Host model: drives the register port the way the serial bus slave engine would
module reg_host_model
	import bridge_audio_link_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic reg_write,
	output logic [7:0] reg_wdata,
	output logic reg_read
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_write = 1'b0;
		reg_wdata = 8'h00;
		reg_read = 1'b0;
	end

	// One write; the released bus shows inverted junk so stale data cannot pass
	task automatic wr(input reg_byte_t a, input reg_byte_t d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	// One read; registered data stands after the read edge, so take it an edge later
	task automatic rd(input reg_byte_t a, output reg_byte_t d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		reg_addr <= ~a;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask : rd
endmodule : reg_host_model

// [tb/tb_bridge_audio_link_ctrl_regs.sv]
// Self-checking bench for the bridge control register block
`include "bridge_audio_link_map.svh"
module tb_bridge_audio_link_ctrl_regs
	import bridge_audio_link_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {reg_byte_t a; reg_byte_t d; reg_byte_t e;} row_t;

	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic config_strap_pin_a = 1'b1;
	logic config_strap_pin_b = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_write, reg_read;
	logic rx_irq = 1'b0;
	logic downstream_detect = 1'b0;
	logic downstream_caps_done = 1'b0;
	logic serial_tx_running = 1'b0;
	logic far_rx_locked = 1'b0;
	logic input_valid = 1'b0;
	logic [1:0] serial_port_mode = 2'h0;
	logic tmds_good = 1'b0;
	logic rx_pll_locked = 1'b0;
	logic [7:0] tmds_freq_mhz = 8'h50;
	logic freq_settled = 1'b0;
	logic [3:0] audio_type = 4'h0;
	logic [7:0] aif_checksum = 8'h00;
	logic [7:0] avi_checksum = 8'h00;
	logic [19:0] acr_n = 20'h00000;
	logic [19:0] acr_cts = 20'h00000;
	logic interrupt_out_n, sequencer_enable, rx_auto_init, remote_edid_load;
	logic tdm_audio_enable, audio_source_local, aux_audio_enable;
	logic tdm_to_parallel_enable, i2s_out_enable, audio_fifo_reset;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	reg_byte_t v;

	// Plain register rows: write, read back, expected value
	row_t rows[7] = '{
		'{`BRIDGE_CONTROL_OFS, 8'hFF, 8'hF7},
		'{`AUDIO_ROUTING_CONFIG_OFS, 8'hFF, 8'hCF},
		'{`LOW_FREQ_THRESHOLD_OFS, 8'hFF, 8'h3F},
		'{`LINK_STATUS_OFS, 8'hFF, 8'h00},
		'{`BRIDGE_STATUS_OFS, 8'hFF, 8'h00},
		'{8'h60, 8'hAA, 8'h00},
		'{`BRIDGE_CONTROL_OFS, 8'h00, 8'h00}};
	// Control byte and the packed outputs it should give with routing at CF
	reg_byte_t ctl[3] = '{8'h00, 8'hF6, 8'h10};
	reg_byte_t ctl_out[3] = '{8'hE3, 8'h1A, 8'hA3};

	always #4 sys_clk = ~sys_clk;

	reg_host_model i_reg_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
		.reg_read(reg_read));

	bridge_audio_link_ctrl_regs i_bridge_audio_link_ctrl_regs (.sys_clk(sys_clk),
		.resetn(resetn), .config_strap_pin_a(config_strap_pin_a),
		.config_strap_pin_b(config_strap_pin_b), .reg_addr(reg_addr),
		.reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
		.rx_irq(rx_irq), .downstream_detect(downstream_detect),
		.downstream_caps_done(downstream_caps_done), .serial_tx_running(serial_tx_running),
		.far_rx_locked(far_rx_locked), .input_valid(input_valid),
		.serial_port_mode(serial_port_mode), .tmds_good(tmds_good),
		.rx_pll_locked(rx_pll_locked), .tmds_freq_mhz(tmds_freq_mhz),
		.freq_settled(freq_settled), .audio_type(audio_type), .aif_checksum(aif_checksum),
		.avi_checksum(avi_checksum), .acr_n(acr_n), .acr_cts(acr_cts),
		.reg_rdata(reg_rdata), .interrupt_out_n(interrupt_out_n),
		.sequencer_enable(sequencer_enable), .rx_auto_init(rx_auto_init),
		.remote_edid_load(remote_edid_load), .tdm_audio_enable(tdm_audio_enable),
		.audio_source_local(audio_source_local), .aux_audio_enable(aux_audio_enable),
		.tdm_to_parallel_enable(tdm_to_parallel_enable), .i2s_out_enable(i2s_out_enable),
		.audio_fifo_reset(audio_fifo_reset));

	task automatic give_verdict();
		if (n_mismatch == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task automatic chk(input string name, input reg_byte_t exp, input reg_byte_t got);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic rchk(input string name, input reg_byte_t a, input reg_byte_t exp);
		reg_byte_t d;
		i_reg_host_model.rd(a, d);
		chk(name, exp, d);
	endtask : rchk

	// Outputs land one cycle after the register, so let two edges pass
	task automatic ochk(input string name, input reg_byte_t exp);
		repeat (2) @(posedge sys_clk);
		#1;
		chk(name, exp, {sequencer_enable, rx_auto_init, remote_edid_load, tdm_audio_enable,
			audio_source_local, aux_audio_enable, tdm_to_parallel_enable, i2s_out_enable});
	endtask : ochk

	// Change one descriptor and count reset pulses over a window longer than the latency
	task automatic bump(input int which, input int exp);
		int n;
		n = 0;
		@(posedge sys_clk);
		case (which)
			0: audio_type <= ~audio_type;
			1: aif_checksum <= aif_checksum + 8'h01;
			2: avi_checksum <= avi_checksum + 8'h01;
			3: acr_n <= acr_n + 20'h00001;
			default: acr_cts <= acr_cts + 20'h00001;
		endcase
		repeat (6)
		begin
			@(posedge sys_clk);
			#1;
			if (audio_fifo_reset === 1'b1)
				n++;
		end
		chk("fifo_pulses", 8'(exp), 8'(n));
	endtask : bump

	// Hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial
	begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		// Power-up values with both straps high
		rchk("ctl_reset", `BRIDGE_CONTROL_OFS, 8'hA1);
		rchk("route_reset", `AUDIO_ROUTING_CONFIG_OFS, 8'h0C);
		rchk("thr_reset", `LOW_FREQ_THRESHOLD_OFS, 8'h06);
		rchk("status_reset", `LINK_STATUS_OFS, 8'h00);
		ochk("outs_strap", 8'h04);
		foreach (rows[i])
		begin
			i_reg_host_model.wr(rows[i].a, rows[i].d);
			rchk("row_read", rows[i].a, rows[i].e);
		end
		foreach (ctl[i])
		begin
			i_reg_host_model.wr(`BRIDGE_CONTROL_OFS, ctl[i]);
			ochk("outs", ctl_out[i]);
		end
		// Interrupt routed only while enabled; pending bit follows the request unmasked, read back while enabled
		i_reg_host_model.wr(`BRIDGE_CONTROL_OFS, 8'h40);
		rx_irq <= 1'b1;
		ochk("outs_irq", 8'hE3);
		chk("irq_pin_on", 8'h00, {7'h00, interrupt_out_n});
		rchk("irq_pending", `BRIDGE_STATUS_OFS, 8'h40);
		i_reg_host_model.wr(`BRIDGE_CONTROL_OFS, 8'h00);
		ochk("outs_irq_off", 8'hE3);
		chk("irq_pin_off", 8'h01, {7'h00, interrupt_out_n});
		// Status, threshold boundary at 3F
		@(posedge sys_clk);
		rx_irq <= 1'b0;
		{downstream_detect, downstream_caps_done, serial_tx_running} <= 3'h7;
		{far_rx_locked, input_valid, tmds_good, rx_pll_locked, freq_settled} <= 5'h1F;
		serial_port_mode <= 2'h1;
		tmds_freq_mhz <= 8'h3F;
		rchk("status_all", `LINK_STATUS_OFS, 8'hDF);
		rchk("status_hold", `LINK_STATUS_OFS, 8'hDF);
		serial_port_mode <= 2'h2;
		tmds_freq_mhz <= 8'h40;
		rchk("status_mode", `LINK_STATUS_OFS, 8'h8D);
		downstream_caps_done <= 1'b0;
		i_reg_host_model.wr(`LINK_STATUS_OFS, 8'hFF);
		rchk("status_caps", `LINK_STATUS_OFS, 8'h0D);
		// FIFO reset policy, one cause at a time
		i_reg_host_model.wr(`AUDIO_ROUTING_CONFIG_OFS, 8'h08);
		bump(0, 1);
		bump(1, 0);
		i_reg_host_model.wr(`AUDIO_ROUTING_CONFIG_OFS, 8'h07);
		bump(0, 0);
		bump(1, 1);
		bump(2, 1);
		bump(3, 1);
		bump(4, 1);
		i_reg_host_model.wr(`BRIDGE_CONTROL_OFS, 8'h80);
		bump(4, 0);
		// Second reset with the straps apart, so a swapped strap shows
		@(posedge sys_clk);
		resetn <= 1'b0;
		{config_strap_pin_a, config_strap_pin_b} <= 2'h2;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rchk("ctl_reset2", `BRIDGE_CONTROL_OFS, 8'h01);
		rchk("route_reset2", `AUDIO_ROUTING_CONFIG_OFS, 8'h0C);
		ochk("outs_reset2", 8'hE4);
		give_verdict();
	end
endmodule : tb_bridge_audio_link_ctrl_regs
